// ### clc_pkg.sv
// constants and types shared by the instruction execution block
// assumes the register bus decodes word indices (byte address / 4)
package clc_pkg;

   // register word indices; byte address is four times the index
   localparam logic [9:0] IDX_OPER    = 10'h000; // opcode and operands
   localparam logic [9:0] IDX_CTX     = 10'h001; // program counter, stack ptr
   localparam logic [9:0] IDX_CMD     = 10'h002; // start strobe
   localparam logic [9:0] IDX_STAT    = 10'h003; // busy, done, write, illegal
   localparam logic [9:0] IDX_RES     = 10'h004; // result and pushed bytes
   localparam logic [9:0] IDX_SYSMODE = 10'h006; // system mode
   localparam logic [9:0] IDX_PEND    = 10'h007; // pending requests
   localparam logic [9:0] IDX_FLAGS   = 10'h0d5; // condition flags

   // reset values
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [7:0]  SYM_RST   = 8'h00;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [7:0]  SP_RST    = 8'h00;

   // global interrupt enable position in system mode
   localparam int SYM_IE = 3;

   // opcodes
   localparam logic [7:0] OP_AND_RR   = 8'h52; // working pair, short form
   localparam logic [7:0] OP_AND_LAST = 8'h56;
   localparam logic [7:0] OP_CMP_RR   = 8'ha2;
   localparam logic [7:0] OP_CMP_LAST = 8'ha6;
   localparam logic [7:0] OP_DEC_R    = 8'h00;
   localparam logic [7:0] OP_DEC_IR   = 8'h01;
   localparam logic [7:0] OP_COM_R    = 8'h60;
   localparam logic [7:0] OP_COM_IR   = 8'h61;
   localparam logic [7:0] OP_CLR_R    = 8'hb0;
   localparam logic [7:0] OP_CLR_IR   = 8'hb1;
   localparam logic [7:0] OP_CCF      = 8'hef;
   localparam logic [7:0] OP_DI       = 8'h8f;
   localparam logic [7:0] OP_EI       = 8'h9f;
   localparam logic [7:0] OP_CALL_DA  = 8'hf6;
   localparam logic [7:0] OP_CALL_IRR = 8'hf4;

   // execution times in cycles
   localparam logic [3:0] CYC_SHORT    = 4'h4;
   localparam logic [3:0] CYC_LONG     = 4'h6;
   localparam logic [3:0] CYC_CALL_DA  = 4'he;
   localparam logic [3:0] CYC_CALL_IRR = 4'hc;
   localparam logic [3:0] CYC_ILLEGAL  = 4'h1;

   // call instruction lengths in bytes
   localparam logic [15:0] LEN_CALL_DA  = 16'h0003;
   localparam logic [15:0] LEN_CALL_IRR = 16'h0002;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // condition flags layout, carry in the top bit
   typedef struct packed {
      logic       c;
      logic       z;
      logic       s;
      logic       v;
      logic [3:0] rsv;
   } clc_flags_t;

   // outcome of one instruction
   typedef struct packed {
      logic [7:0]  res;
      logic        we;
      logic        illegal;
      clc_flags_t  flags;
      logic [7:0]  system_mode;
      logic [15:0] npc;
      logic [7:0]  nsp;
      logic [7:0]  push_lo;
      logic [7:0]  push_hi;
   } clc_exec_t;

   typedef enum logic [0:0] {
      CLC_IDLE,
      CLC_EXEC
   } clc_state_t;

endpackage

// ### clc_exec.sv
// execution unit for and, compare, decrement, complement, clear,
// carry complement, call and global interrupt enable and disable
// assumes an axi4-lite master and synchronous interrupt request inputs
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// RQ1 - and stores dst and src, 4 or 6 cycles
// RQ2 - and keeps carry, sets z s, clears v
// RQ3 - call pushes low then high, loads target
// RQ4 - pushed address follows call; flags untouched
// RQ5 - carry complement inverts carry only, 4 cycles
// RQ6 - clear writes zero, flags untouched
// RQ7 - complement inverts every destination bit
// RQ8 - complement keeps carry, sets z s, v zero
// RQ9 - compare subtracts, writes neither operand
// RQ10 - compare carry set on borrow
// RQ11 - compare overflow per sign rule
// RQ12 - decrement subtracts one, carry kept
// RQ13 - decrement overflow only from 80h
// RQ14 - disable clears mode bit 3, flags kept
// RQ15 - requests still latch while disabled
// RQ16 - enable sets mode bit 3, flags kept
// RQ17 - pending requests serviced after enable
// RQ18 - results eight bits, sign from top bit
module clc_exec #(
   parameter int N_IRQ = 8  // number of interrupt request lines
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [N_IRQ-1:0]  irq_req,
   output logic [N_IRQ-1:0]       irq_pending,
   output logic                   irq_service,
   output logic                   busy
);

   // merge a write word into a stored word under byte strobes
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = dat[8*i +: 8];
         end
      end
      return r;
   endfunction

   // zero and sign from an eight bit result
   function automatic clc_pkg::clc_flags_t zs(input clc_pkg::clc_flags_t f,
                                              input logic [7:0] v);
      clc_pkg::clc_flags_t r;
      r   = f;
      r.z = (v == 8'h00); // RQ18
      r.s = v[7];         // RQ18
      return r;
   endfunction

   // execution time of an opcode; unknown opcodes take one cycle
   function automatic logic [3:0] cyc_of(input logic [7:0] op);
      logic [3:0] c;
      c = clc_pkg::CYC_ILLEGAL;
      if (op == clc_pkg::OP_AND_RR || op == clc_pkg::OP_CMP_RR) begin
         c = clc_pkg::CYC_SHORT;
      end else if ((op > clc_pkg::OP_AND_RR && op <= clc_pkg::OP_AND_LAST) ||
                   (op > clc_pkg::OP_CMP_RR && op <= clc_pkg::OP_CMP_LAST)) begin
         c = clc_pkg::CYC_LONG;
      end else if (op == clc_pkg::OP_CALL_DA) begin
         c = clc_pkg::CYC_CALL_DA;
      end else if (op == clc_pkg::OP_CALL_IRR) begin
         c = clc_pkg::CYC_CALL_IRR;
      end else if (op == clc_pkg::OP_DEC_R || op == clc_pkg::OP_DEC_IR ||
                   op == clc_pkg::OP_COM_R || op == clc_pkg::OP_COM_IR ||
                   op == clc_pkg::OP_CLR_R || op == clc_pkg::OP_CLR_IR ||
                   op == clc_pkg::OP_CCF   || op == clc_pkg::OP_DI     ||
                   op == clc_pkg::OP_EI) begin
         c = clc_pkg::CYC_SHORT;
      end
      return c;
   endfunction

   // bus channel state
   logic        awready_r;  // low once an address is held
   logic        wready_r;   // low once data is held
   logic [9:0]  awidx_r;    // held write word index
   logic [31:0] wdata_r;    // held write data
   logic [3:0]  wstrb_r;    // held write strobes
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   // architectural and result state
   logic [31:0]         oper_r;    // opcode, dst, src
   logic [15:0]         pc_r;      // address of the instruction
   logic [7:0]          sp_r;      // stack pointer
   clc_pkg::clc_flags_t flags_r;
   logic [7:0]          sym_r;     // system mode
   logic [N_IRQ-1:0]    pend_r;    // pending requests
   logic                irq_service_r;
   logic [7:0]          res_r;
   logic [7:0]          push_lo_r;
   logic [7:0]          push_hi_r;
   logic                we_r;      // last result targets the destination
   logic                ill_r;     // last opcode not in this group
   logic                done_r;
   clc_pkg::clc_state_t state_r;
   logic [3:0]          cnt_r;     // cycles left minus one

   // write decode: both halves held and no response pending
   wire        wr_fire  = !awready_r && !wready_r && !bvalid_r;
   wire        idle_w   = (state_r == clc_pkg::CLC_IDLE);
   wire        wr_oper  = wr_fire && awidx_r == clc_pkg::IDX_OPER && idle_w;
   wire        wr_ctx   = wr_fire && awidx_r == clc_pkg::IDX_CTX && idle_w;
   wire        wr_flags = wr_fire && awidx_r == clc_pkg::IDX_FLAGS;
   wire        wr_sym   = wr_fire && awidx_r == clc_pkg::IDX_SYSMODE;
   wire        wr_pend  = wr_fire && awidx_r == clc_pkg::IDX_PEND;
   wire        start_w  = wr_fire && awidx_r == clc_pkg::IDX_CMD &&
                          wstrb_r[0] && wdata_r[0] && idle_w;
   wire        wr_map   = awidx_r == clc_pkg::IDX_OPER  ||
                          awidx_r == clc_pkg::IDX_CTX   ||
                          awidx_r == clc_pkg::IDX_CMD   ||
                          awidx_r == clc_pkg::IDX_STAT  ||
                          awidx_r == clc_pkg::IDX_RES   ||
                          awidx_r == clc_pkg::IDX_FLAGS ||
                          awidx_r == clc_pkg::IDX_SYSMODE ||
                          awidx_r == clc_pkg::IDX_PEND;
   wire [31:0] wmerged  = wmerge(32'h0000_0000, wdata_r, wstrb_r);
   wire [31:0] oper_nxt = wmerge(oper_r, wdata_r, wstrb_r);
   wire [31:0] ctx_nxt  = wmerge({8'h00, sp_r, pc_r}, wdata_r, wstrb_r);

   // operand fields
   wire [7:0] op_w  = oper_r[7:0];
   wire [7:0] dst_w = oper_r[15:8];   // also call target high byte
   wire [7:0] src_w = oper_r[23:16];  // also call target low byte

   // final cycle of an instruction
   wire commit_w = (state_r == clc_pkg::CLC_EXEC) && (cnt_r == 4'h0);

   // opcode classes
   wire is_and = op_w >= clc_pkg::OP_AND_RR && op_w <= clc_pkg::OP_AND_LAST;
   wire is_cmp = op_w >= clc_pkg::OP_CMP_RR && op_w <= clc_pkg::OP_CMP_LAST;
   wire is_dec = op_w == clc_pkg::OP_DEC_R || op_w == clc_pkg::OP_DEC_IR;
   wire is_com = op_w == clc_pkg::OP_COM_R || op_w == clc_pkg::OP_COM_IR;
   wire is_clr = op_w == clc_pkg::OP_CLR_R || op_w == clc_pkg::OP_CLR_IR;
   wire is_cal = op_w == clc_pkg::OP_CALL_DA || op_w == clc_pkg::OP_CALL_IRR;

   // arithmetic shared by the classes
   wire [8:0]  diff_w = {1'b0, dst_w} - {1'b0, src_w};
   wire [7:0]  and_w  = dst_w & src_w;
   wire [7:0]  com_w  = ~dst_w;
   wire [7:0]  dec_w  = dst_w - 8'h01;
   wire [15:0] ret_w  = pc_r + ((op_w == clc_pkg::OP_CALL_DA) ?
                        clc_pkg::LEN_CALL_DA : clc_pkg::LEN_CALL_IRR);

   // outcome of the held instruction; applied only at commit
   clc_pkg::clc_exec_t ex;
   always_comb begin
      ex         = '0;
      ex.res     = dst_w;
      ex.flags   = flags_r;
      ex.system_mode     = sym_r;
      ex.npc     = pc_r;
      ex.nsp     = sp_r;
      ex.push_lo = push_lo_r;
      ex.push_hi = push_hi_r;
      if (is_and) begin
         ex.res     = and_w;                    // RQ1
         ex.we      = 1'b1;
         ex.flags   = zs(flags_r, and_w);       // RQ2
         ex.flags.v = 1'b0;                     // RQ2
      end else if (is_cmp) begin
         // flags only; the destination is not written
         ex.res     = diff_w[7:0];              // RQ9
         ex.flags   = zs(flags_r, diff_w[7:0]); // RQ10
         ex.flags.c = diff_w[8];                // RQ10
         ex.flags.v = (dst_w[7] != src_w[7]) &&
                      (diff_w[7] == src_w[7]);  // RQ11
      end else if (is_dec) begin
         ex.res     = dec_w;                    // RQ12
         ex.we      = 1'b1;
         ex.flags   = zs(flags_r, dec_w);       // RQ13
         ex.flags.v = (dst_w == 8'h80);         // RQ13
      end else if (is_com) begin
         ex.res     = com_w;                    // RQ7
         ex.we      = 1'b1;
         ex.flags   = zs(flags_r, com_w);       // RQ8
         ex.flags.v = 1'b0;                     // RQ8
      end else if (is_clr) begin
         ex.res     = 8'h00;                    // RQ6
         ex.we      = 1'b1;
      end else if (op_w == clc_pkg::OP_CCF) begin
         ex.flags.c = !flags_r.c;               // RQ5
      end else if (op_w == clc_pkg::OP_DI) begin
         ex.system_mode[clc_pkg::SYM_IE] = 1'b0;        // RQ14
      end else if (op_w == clc_pkg::OP_EI) begin
         ex.system_mode[clc_pkg::SYM_IE] = 1'b1;        // RQ16
      end else if (is_cal) begin
         // low byte goes to sp-1, high byte to sp-2
         ex.push_lo = ret_w[7:0];               // RQ3
         ex.push_hi = ret_w[15:8];              // RQ4
         ex.nsp     = sp_r - 8'h02;             // RQ3
         ex.npc     = {dst_w, src_w};           // RQ3
      end else begin
         ex.illegal = 1'b1;
      end
   end

   // sequencer: load the cycle count, run it down, commit at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= clc_pkg::CLC_IDLE;
         cnt_r   <= 4'h0;
      end else if (start_w) begin
         state_r <= clc_pkg::CLC_EXEC;
         cnt_r   <= cyc_of(op_w) - 4'h1;        // RQ1
      end else if (commit_w) begin
         state_r <= clc_pkg::CLC_IDLE;
      end else if (state_r == clc_pkg::CLC_EXEC) begin
         cnt_r   <= cnt_r - 4'h1;
      end
   end

   // result registers; done clears on start, sets on commit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_r     <= 8'h00;
         push_lo_r <= 8'h00;
         push_hi_r <= 8'h00;
         we_r      <= 1'b0;
         ill_r     <= 1'b0;
         done_r    <= 1'b0;
      end else if (commit_w) begin
         res_r     <= ex.res;
         push_lo_r <= ex.push_lo;
         push_hi_r <= ex.push_hi;
         we_r      <= ex.we;
         ill_r     <= ex.illegal;
         done_r    <= 1'b1;
      end else if (start_w) begin
         done_r    <= 1'b0;
      end
   end

   // operands are frozen while an instruction runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oper_r <= 32'h0000_0000;
         pc_r   <= clc_pkg::PC_RST;
         sp_r   <= clc_pkg::SP_RST;
      end else if (commit_w) begin
         pc_r   <= ex.npc;                      // RQ3
         sp_r   <= ex.nsp;
      end else begin
         if (wr_oper) begin
            oper_r <= oper_nxt;
         end
         if (wr_ctx) begin
            pc_r <= ctx_nxt[15:0];
            sp_r <= ctx_nxt[23:16];
         end
      end
   end

   // flags and mode: the instruction wins over a same-cycle write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_r <= clc_pkg::FLAGS_RST;
         sym_r   <= clc_pkg::SYM_RST;
      end else if (commit_w) begin
         flags_r <= ex.flags;
         sym_r   <= ex.system_mode;
      end else begin
         if (wr_flags && wstrb_r[0]) begin
            flags_r <= {wdata_r[7:4], 4'h0};
         end
         if (wr_sym && wstrb_r[0]) begin
            sym_r <= wdata_r[7:0];
         end
      end
   end

   // pending bits latch regardless of the enable; set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_r        <= '0;
         irq_service_r <= 1'b0;
      end else begin
         pend_r        <= (pend_r & ~(wr_pend ? wmerged[N_IRQ-1:0] : '0))
                          | irq_req;            // RQ15
         irq_service_r <= sym_r[clc_pkg::SYM_IE] && (|pend_r); // RQ17
      end
   end

   // write channels: hold address and data, answer when both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         awidx_r   <= 10'h000;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= clc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awidx_r   <= s_axi_awaddr[11:2];
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r) begin
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            wready_r <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_map ? clc_pkg::RESP_OKAY : clc_pkg::RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // read decode; unmapped words read zero with an error
   logic [31:0] rd_w;
   logic        rd_ok;
   wire  [9:0]  aridx = s_axi_araddr[11:2];
   always_comb begin
      rd_w  = 32'h0000_0000;
      rd_ok = 1'b1;
      if (aridx == clc_pkg::IDX_OPER) begin
         rd_w = oper_r;
      end else if (aridx == clc_pkg::IDX_CTX) begin
         rd_w = {8'h00, sp_r, pc_r};
      end else if (aridx == clc_pkg::IDX_CMD) begin
         rd_w = 32'h0000_0000;
      end else if (aridx == clc_pkg::IDX_STAT) begin
         rd_w = {28'h0000000, ill_r, we_r, done_r, !idle_w};
      end else if (aridx == clc_pkg::IDX_RES) begin
         rd_w = {8'h00, push_hi_r, push_lo_r, res_r};
      end else if (aridx == clc_pkg::IDX_FLAGS) begin
         rd_w = {24'h000000, flags_r};
      end else if (aridx == clc_pkg::IDX_SYSMODE) begin
         rd_w = {24'h000000, sym_r};
      end else if (aridx == clc_pkg::IDX_PEND) begin
         rd_w = 32'(pend_r);
      end else begin
         rd_ok = 1'b0;
      end
   end

   // read channel: one read at a time, data one cycle after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= clc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_w;
         rresp_r   <= rd_ok ? clc_pkg::RESP_OKAY : clc_pkg::RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // outputs straight from flip-flops
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign irq_pending   = pend_r;
   assign irq_service   = irq_service_r;
   assign busy          = (state_r == clc_pkg::CLC_EXEC);

   property p_and_time;
      @(posedge aclk) disable iff (!aresetn)
      start_w && op_w == clc_pkg::OP_AND_RR |-> !commit_w [*4] ##1 commit_w;
   endproperty
   a_and_time: assert property (p_and_time) // RQ1
      else $error("short and form not committed after 4 cycles");

   property p_and_flags;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && is_and |=> !flags_r.v && flags_r.c == $past(flags_r.c)
         && res_r == ($past(dst_w) & $past(src_w));
   endproperty
   a_and_flags: assert property (p_and_flags) // RQ2
      else $error("and result or flags wrong");

   property p_call_time;
      @(posedge aclk) disable iff (!aresetn)
      start_w && op_w == clc_pkg::OP_CALL_DA |-> ##14 commit_w;
   endproperty
   a_call_time: assert property (p_call_time) // RQ3
      else $error("direct call not committed after 14 cycles");

   property p_call_ret;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && op_w == clc_pkg::OP_CALL_DA |=>
         {push_hi_r, push_lo_r} == $past(pc_r) + 16'h0003
         && flags_r == $past(flags_r) && sp_r == $past(sp_r) - 8'h02;
   endproperty
   a_call_ret: assert property (p_call_ret) // RQ4
      else $error("call return address or stack wrong");

   property p_ccf;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && op_w == clc_pkg::OP_CCF |=> flags_r.c != $past(flags_r.c)
         && flags_r[6:0] == $past(flags_r[6:0]);
   endproperty
   a_ccf: assert property (p_ccf) // RQ5
      else $error("carry complement wrong");

   property p_cmp_carry;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && is_cmp |=> !we_r && flags_r.c == ($past(src_w) > $past(dst_w));
   endproperty
   a_cmp_carry: assert property (p_cmp_carry) // RQ10
      else $error("compare borrow wrong");

   property p_dec_v;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && is_dec |=> flags_r.v == ($past(dst_w) == 8'h80)
         && flags_r.c == $past(flags_r.c);
   endproperty
   a_dec_v: assert property (p_dec_v) // RQ13
      else $error("decrement overflow wrong");

   property p_di;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && op_w == clc_pkg::OP_DI |=> !sym_r[3] ##1 !irq_service_r;
   endproperty
   a_di: assert property (p_di) // RQ14
      else $error("disable did not stop servicing");

   property p_ei;
      @(posedge aclk) disable iff (!aresetn)
      commit_w && op_w == clc_pkg::OP_EI |=> sym_r[3] && flags_r == $past(flags_r);
   endproperty
   a_ei: assert property (p_ei) // RQ16
      else $error("enable did not set mode bit");

   property p_pend;
      @(posedge aclk) disable iff (!aresetn)
      |irq_req |=> (pend_r & $past(irq_req)) == $past(irq_req);
   endproperty
   a_pend: assert property (p_pend) // RQ15
      else $error("request not latched as pending");

   property p_service;
      @(posedge aclk) disable iff (!aresetn)
      sym_r[3] && (|pend_r) |=> irq_service_r;
   endproperty
   a_service: assert property (p_service) // RQ17
      else $error("pending request not serviced while enabled");

endmodule

// ### clc_exec_pad.sv
`timescale 1ns/1ps

// ### cpu_logic_call_intctl_ops_tb.sv
// self-checking bench for the instruction execution block
// assumes the block alone, driven over its axi4-lite register port
`timescale 1ns/1ps
module cpu_logic_call_intctl_ops_tb;
   logic        aclk = 1'b0;  // 100 mhz core clock
   logic        aresetn = 1'b0; // synchronous, active low
   logic [11:0] awa = '0;     // write address channel
   logic [11:0] ara = '0;     // read address channel
   logic [31:0] wd = '0;      // write data
   logic [31:0] rdat;         // last read data
   logic        awv = '0, wv = '0, bre = '0, arv = '0, rre = '0;
   logic        awr, wrdy, bv, arr, rv, srv, busy;
   logic [1:0]  br, rr;       // write and read responses
   logic [7:0]  irq = '0;     // interrupt request lines
   logic [7:0]  pend;         // sticky pending bits
   int          num_errors = 0, n_tests = 0, cyc = 0, bcnt = 0;
   always #5 aclk = ~aclk;
   // busy cycle counter and hang guard
   always @(posedge aclk) begin
      if (busy === 1'b1) bcnt <= bcnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   clc_exec DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .irq_req(irq), .irq_pending(pend),
      .irq_service(srv), .busy(busy));
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // each channel released when taken; one idle edge keeps drives apart
   task wr(input logic [11:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         if (bv) break;
      end
      bre <= 1'b0;
      @(posedge aclk);
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] m, e);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      rre <= 1'b0;
      chk(rdat & m, e);
      @(posedge aclk);
   endtask
   // loads one instruction, starts it and checks its busy length
   task ex(input logic [7:0] op, d, s, input int n,
           input logic [15:0] pc = 16'h0, input logic [7:0] sp = 8'h0);
      wr(12'h000, {8'h00, s, d, op});
      wr(12'h004, {8'h00, sp, pc});
      bcnt = 0;
      wr(12'h008, 32'h1);
      while (busy === 1'b1) @(posedge aclk);
      chk(bcnt, n);
   endtask
   task t_and;
      wr(12'h354, 32'h80);
      ex(8'h52, 8'h12, 8'h03, 4);
      rchk(12'h010, 32'hff, 32'h02);
      rchk(12'h354, 32'hff, 32'h80);
      rchk(12'h00c, 32'h4, 32'h4);
      ex(8'h56, 8'hf1, 8'h80, 6);
      rchk(12'h010, 32'hff, 32'h80);
      rchk(12'h354, 32'hff, 32'ha0);
   endtask
   task t_cmp;
      ex(8'ha2, 8'h02, 8'h03, 4);
      rchk(12'h00c, 32'h4, 32'h0);
      rchk(12'h354, 32'hff, 32'ha0);
      ex(8'ha4, 8'h80, 8'h01, 6);
      rchk(12'h354, 32'hff, 32'h10);
   endtask
   task t_dec;
      wr(12'h354, 32'h80);
      ex(8'h00, 8'h80, 8'h00, 4);
      rchk(12'h010, 32'hff, 32'h7f);
      rchk(12'h354, 32'hff, 32'h90);
      ex(8'h01, 8'h01, 8'h00, 4);
      rchk(12'h354, 32'hff, 32'hc0);
   endtask
   task t_misc;
      ex(8'h60, 8'h07, 8'h00, 4);
      rchk(12'h010, 32'hff, 32'hf8);
      rchk(12'h354, 32'hff, 32'ha0);
      ex(8'hb0, 8'h4f, 8'h00, 4);
      rchk(12'h010, 32'hff, 32'h00);
      rchk(12'h354, 32'hff, 32'ha0);
      ex(8'hef, 8'h00, 8'h00, 4);
      rchk(12'h354, 32'hff, 32'h20);
   endtask
   task t_call;
      ex(8'hf6, 8'h15, 8'h21, 14, 16'h1a47, 8'hb2);
      rchk(12'h010, 32'hffff00, 32'h1a4a00);
      rchk(12'h004, 32'hffffff, 32'hb01521);
      rchk(12'h354, 32'hff, 32'h20);
      ex(8'hf4, 8'h15, 8'h21, 12, 16'h1a47, 8'hb2);
      rchk(12'h010, 32'hffff00, 32'h1a4900);
   endtask
   // a request held off while disabled is serviced after enable
   task t_irq;
      // enable first, so that a disable that does nothing is caught
      wr(12'h018, 32'h08);
      ex(8'h8f, 8'h00, 8'h00, 4);
      rchk(12'h018, 32'hff, 32'h00);
      irq <= 8'h04;
      @(posedge aclk);
      irq <= 8'h00;
      repeat (3) @(posedge aclk);
      chk({24'h0, pend}, 32'h4);
      chk({31'h0, srv}, 32'h0);
      ex(8'h9f, 8'h00, 8'h00, 4);
      rchk(12'h018, 32'hff, 32'h08);
      chk({31'h0, srv}, 32'h1);
      rchk(12'h354, 32'hff, 32'h20);
      wr(12'h020, 32'h0);
      chk({30'h0, br}, 32'h2);
      // unmapped word reads zero with an error response
      rchk(12'h020, 32'hffffffff, 32'h0);
      chk({30'h0, rr}, 32'h2);
   endtask
   task give_verdict;
      $display("errors %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_and;
      t_cmp;
      t_dec;
      t_misc;
      t_call;
      t_irq;
      give_verdict;
   end
endmodule
